//--- eid_defs.svh
`ifndef EID_DEFS_SVH
`define EID_DEFS_SVH

`define EID_OFS_CFG_LOW    12'h020
`define EID_OFS_CFG_HIGH   12'h024
`define EID_OFS_CLEAR      12'h030
`define EID_OFS_NMI_CLEAR  12'h034
`define EID_OFS_STATUS     12'h040
`define EID_OFS_MASK       12'h044
`define EID_OFS_PENDING    12'h048
`define EID_RST_VAL        16'h0000
`define EID_REG_W          16
`define EID_NUM_IRQ        8
`define EID_GRP_W          4
`define EID_MODE_W         3
`define EID_EN_BIT         3
`define EID_ADDR_W         12
`define EID_RESP_OKAY      2'h0
`define EID_RESP_SLVERR    2'h2

`endif

//--- eid_pin_model.sv
`timescale 1ns/100ps
module eid_pin_model (
  input  wire logic       clk_sys,
  output logic      [7:0] ext_irq_pin
);
  initial ext_irq_pin = 8'h00;
  // whole cycles only: a shorter level may be missed
  task automatic drive(input logic [7:0] v, input int n);
    ext_irq_pin <= v;
    repeat (n) @(posedge clk_sys);
  endtask
endmodule

//--- eid_pkg.sv
package eid_pkg;
  typedef enum logic [2:0] {
    EID_RISE   = 3'h0,
    EID_FALL   = 3'h1,
    EID_BOTH   = 3'h2,
    EID_HIGH   = 3'h3,
    EID_LOW    = 3'h4,
    EID_FALL_B = 3'h5,
    EID_BOTH_B = 3'h6,
    EID_HIGH_B = 3'h7
  } eid_mode_e;

  typedef enum {
    EID_W_IDLE,
    EID_W_RESP
  } eid_wr_state_e;

  typedef struct packed {
    logic [15:0]   cfg_low_r;
    logic [15:0]   cfg_high_r;
    logic [15:0]   clear_r;
    logic [15:0]   nmi_clear_r;
    logic [7:0]    status_r;
    logic [7:0]    mask_r;
    logic [7:0]    sync1_r;
    logic [7:0]    sync2_r;
    logic [7:0]    prev_r;
    logic [7:0]    req_r;
    logic          aw_got_r;
    logic          w_got_r;
    logic [11:0]   awaddr_r;
    logic [31:0]   wdata_r;
    logic [3:0]    wstrb_r;
    logic          bvalid_r;
    logic [1:0]    bresp_r;
    logic          rvalid_r;
    logic [31:0]   rdata_r;
    logic [1:0]    rresp_r;
  } eid_state_s;
endpackage

//--- eid_unit.sv
`timescale 1ns/100ps
`include "eid_defs.svh"

// What this block does
// - eight inputs, each configured independently
// - edge modes give one-cycle request pulse
// - level modes hold request while level present
// - always-on logic, request drives wake output
// - configuration registers at 0x20 and 0x24
// - clear registers at 0x30 and 0x34
// - all registers reset to zero
// - three-bit mode codes with aliases
// - enable bit above mode, 4-bit groups
// - clear bit per interrupt, upper reserved at 0x30; 0x34 keeps all 16 bits
module eid_unit #(
  parameter int NUM_IRQ = `EID_NUM_IRQ
) (
  input  wire logic                clk_sys,
  input  wire logic                sys_rst,
  input  wire logic [NUM_IRQ-1:0]  ext_irq_pin,
  output logic [NUM_IRQ-1:0]       core_irq_req,
  output logic                     wake_req,
  output logic                     irq,
  input  wire logic [11:0]         s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [11:0]         s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready
);

  eid_pkg::eid_state_s st_r;
  eid_pkg::eid_state_s st_nxt;

  logic [31:0]       cfg_all;
  logic [7:0]        det;
  logic [7:0]        clr_hit;
  logic              wr_fire;
  logic [15:0]       wmask;

  // ------------------------------------------------------------
  // detection
  // ------------------------------------------------------------
  assign cfg_all = {st_r.cfg_high_r, st_r.cfg_low_r};

  always_comb begin
    det = 8'h00;
    for (int i = 0; i < 8; i++) begin
      logic [3:0] grp;
      logic       cur;
      logic       old;
      grp = cfg_all[i*`EID_GRP_W +: `EID_GRP_W];
      cur = st_r.sync2_r[i];
      old = st_r.prev_r[i];
      if (grp[`EID_EN_BIT]) begin
        case (eid_pkg::eid_mode_e'(grp[`EID_MODE_W-1:0]))
          eid_pkg::EID_RISE:   det[i] = cur & ~old;
          eid_pkg::EID_FALL,
          eid_pkg::EID_FALL_B: det[i] = ~cur & old;
          eid_pkg::EID_BOTH,
          eid_pkg::EID_BOTH_B: det[i] = cur ^ old;
          eid_pkg::EID_HIGH,
          eid_pkg::EID_HIGH_B: det[i] = cur;
          eid_pkg::EID_LOW:    det[i] = ~cur;
          default:             det[i] = 1'b0;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // register bus and state update
  // ------------------------------------------------------------
  assign wr_fire = st_r.aw_got_r & st_r.w_got_r & ~st_r.bvalid_r;
  assign wmask   = {{8{st_r.wstrb_r[1]}}, {8{st_r.wstrb_r[0]}}};
  // status is write-one-clear at its own address too, so software can pick either
  assign clr_hit = (wr_fire && (st_r.awaddr_r == `EID_OFS_CLEAR || st_r.awaddr_r == `EID_OFS_STATUS)) ?
                   (st_r.wdata_r[7:0] & wmask[7:0]) : 8'h00;

  always_comb begin
    st_nxt = st_r;
    // two-stage sync; stage one feeds only stage two
    st_nxt.sync1_r = ext_irq_pin;
    st_nxt.sync2_r = st_r.sync1_r;
    st_nxt.prev_r  = st_r.sync2_r;
    st_nxt.req_r   = det;
    // set beats write-one clear in the same cycle
    st_nxt.status_r = (st_r.status_r & ~clr_hit) | det;

    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.aw_got_r = 1'b1;
      st_nxt.awaddr_r = {s_axi_awaddr[11:2], 2'b00};
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.w_got_r = 1'b1;
      st_nxt.wdata_r = s_axi_wdata;
      st_nxt.wstrb_r = s_axi_wstrb;
    end

    if (wr_fire) begin
      st_nxt.aw_got_r = 1'b0;
      st_nxt.w_got_r  = 1'b0;
      st_nxt.bvalid_r = 1'b1;
      st_nxt.bresp_r  = `EID_RESP_OKAY;
      case (st_r.awaddr_r)
        `EID_OFS_CFG_LOW:
          st_nxt.cfg_low_r = (st_r.cfg_low_r & ~wmask) | (st_r.wdata_r[15:0] & wmask);
        `EID_OFS_CFG_HIGH:
          st_nxt.cfg_high_r = (st_r.cfg_high_r & ~wmask) | (st_r.wdata_r[15:0] & wmask);
        `EID_OFS_CLEAR:
          st_nxt.clear_r = {8'h00, (st_r.clear_r[7:0] & ~wmask[7:0]) | (st_r.wdata_r[7:0] & wmask[7:0])};
        `EID_OFS_NMI_CLEAR:
          st_nxt.nmi_clear_r = (st_r.nmi_clear_r & ~wmask) | (st_r.wdata_r[15:0] & wmask);
        `EID_OFS_STATUS: ;
        `EID_OFS_MASK:
          if (st_r.wstrb_r[0]) begin
            st_nxt.mask_r = st_r.wdata_r[7:0];
          end
        default:
          st_nxt.bresp_r = `EID_RESP_SLVERR;
      endcase
    end
    if (st_r.bvalid_r && s_axi_bready) begin
      st_nxt.bvalid_r = 1'b0;
    end

    if (s_axi_arvalid && s_axi_arready) begin
      st_nxt.rvalid_r = 1'b1;
      st_nxt.rresp_r  = `EID_RESP_OKAY;
      case ({s_axi_araddr[11:2], 2'b00})
        `EID_OFS_CFG_LOW:   st_nxt.rdata_r = {16'h0000, st_r.cfg_low_r};
        `EID_OFS_CFG_HIGH:  st_nxt.rdata_r = {16'h0000, st_r.cfg_high_r};
        `EID_OFS_CLEAR:     st_nxt.rdata_r = {16'h0000, st_r.clear_r};
        `EID_OFS_NMI_CLEAR: st_nxt.rdata_r = {16'h0000, st_r.nmi_clear_r};
        `EID_OFS_STATUS:    st_nxt.rdata_r = {24'h000000, st_r.status_r};
        `EID_OFS_MASK:      st_nxt.rdata_r = {24'h000000, st_r.mask_r};
        `EID_OFS_PENDING:   st_nxt.rdata_r = {24'h000000, st_r.req_r};
        default: begin
          st_nxt.rdata_r = 32'h0000_0000;
          st_nxt.rresp_r = `EID_RESP_SLVERR;
        end
      endcase
    end else if (st_r.rvalid_r && s_axi_rready) begin
      st_nxt.rvalid_r = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign s_axi_awready = ~st_r.aw_got_r & ~st_r.bvalid_r;
  assign s_axi_wready  = ~st_r.w_got_r & ~st_r.bvalid_r;
  assign s_axi_bvalid  = st_r.bvalid_r;
  assign s_axi_bresp   = st_r.bresp_r;
  assign s_axi_arready = ~st_r.rvalid_r;
  assign s_axi_rvalid  = st_r.rvalid_r;
  assign s_axi_rdata   = st_r.rdata_r;
  assign s_axi_rresp   = st_r.rresp_r;
  assign core_irq_req  = st_r.req_r;
  // wake is unmasked so hibernate exit needs no mask setup
  assign wake_req      = |st_r.req_r;
  assign irq           = |(st_r.status_r & st_r.mask_r);

endmodule

//--- eid_unit_properties.sv
`timescale 1ns/100ps
module eid_unit_properties (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic [7:0]  core_irq_req,
  input wire logic        wake_req,
  input wire logic        irq,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_wake_any: assert property (wake_req == |core_irq_req) else $error("wake");
  a_rst_quiet: assert property ($past(sys_rst) |-> (core_irq_req == 8'h00 && !irq) [*2]) else $error("rst");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("rd");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("b");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar");
  a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("aw");
  a_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000) else $error("up");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property ($rose(irq));
  cover property (s_axi_rvalid && !s_axi_rready);
endmodule
bind eid_unit eid_unit_properties chk_u (.clk_sys, .sys_rst, .core_irq_req, .wake_req, .irq, .s_axi_awready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

//--- ext_irq_detect_unit_tb_top.sv
`timescale 1ns/100ps
`include "eid_defs.svh"
module ext_irq_detect_unit_tb_top;
  logic        clk_sys = 1'h0, sys_rst = 1'h1, cnt_on = 1'h0;
  logic [7:0]  ext_irq_pin, core_irq_req;
  logic        wake_req, irq, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  int          bad_count = 0, comparisons = 0, cyc = 0, hits, stray, sel, wk;
  always #4 clk_sys = ~clk_sys;
  eid_unit dut_u (.clk_sys, .sys_rst, .ext_irq_pin, .core_irq_req, .wake_req, .irq, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  eid_pin_model pm_u (.clk_sys, .ext_irq_pin);
  // ------------------------------------------------------------
  // bus tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input int late = 0);
    logic ta, tw;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= (late == 0);
    do begin
      @(negedge clk_sys);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      @(posedge clk_sys);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
    end while ((s_axi_awvalid & !ta) | (s_axi_wvalid & !tw));
    // late ready makes the slave hold its response
    if (late > 0) begin
      repeat (late) @(posedge clk_sys);
      s_axi_bready <= 1'h1;
    end
    do @(negedge clk_sys); while (!s_axi_bvalid);
    rs = s_axi_bresp;
    @(posedge clk_sys);
    s_axi_bready <= 1'h0;
  endtask
  task automatic rdr(input logic [11:0] a, input int late = 0);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= (late == 0);
    do @(negedge clk_sys); while (!s_axi_arready);
    @(posedge clk_sys);
    s_axi_arvalid <= 1'h0;
    if (late > 0) begin
      repeat (late) @(posedge clk_sys);
      s_axi_rready <= 1'h1;
    end
    do @(negedge clk_sys); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    @(posedge clk_sys);
    s_axi_rready <= 1'h0;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    logic [11:0] a [4] = '{12'h020, 12'h024, 12'h030, 12'h034};
    logic [31:0] d [4] = '{32'hABCD7777, 32'h00005555, 32'h000000A5, 32'h0000C3C3};
    foreach (a[i]) begin
      rdr(a[i]);
      chk(rd, 32'h0);
      wr(a[i], d[i]);
      chk(rs, `EID_RESP_OKAY);
      rdr(a[i]);
      chk(rd, d[i] & 32'hFFFF);
      wr(a[i], 32'h0);
    end
    wr(12'h100, 32'h1);
    chk(rs, `EID_RESP_SLVERR);
    rdr(12'h100);
    chk(rs, `EID_RESP_SLVERR);
    $display("regs done");
  endtask
  always @(posedge clk_sys) if (cnt_on) begin
    hits += core_irq_req[sel];
    wk += wake_req;
    stray += int'((core_irq_req & ~(8'h01 << sel)) != 8'h00);
  end
  task automatic t_modes;
    int exp [8] = '{1, 1, 2, 6, 6, 1, 2, 6};
    logic [7:0] p0;
    for (int m = 0; m < 8; m++) begin
      p0 = (m == 4) ? 8'h10 : 8'h00;
      pm_u.drive(p0, 4);
      sel = m;
      hits = 0;
      stray = 0;
      wk = 0;
      cnt_on <= 1'h1;
      wr(m < 4 ? 12'h020 : 12'h024, 32'(4'h8 | m) << (4 * (m % 4)));
      pm_u.drive(p0 ^ (8'h01 << m), 6);
      pm_u.drive(p0, 6);
      wr(m < 4 ? 12'h020 : 12'h024, 32'h0);
      cnt_on <= 1'h0;
      chk(32'(hits), 32'(exp[m]));
      chk(32'(stray), 32'h0);
      chk(32'(wk), 32'(exp[m]));
    end
    $display("modes done");
  endtask
  task automatic t_status;
    rdr(`EID_OFS_STATUS, 2);
    chk(rd, 32'hFF);
    chk(32'(irq), 32'h0);
    wr(`EID_OFS_MASK, 32'h10, 2);
    chk(32'(irq), 32'h1);
    wr(`EID_OFS_CLEAR, 32'h10);
    chk(32'(irq), 32'h0);
    rdr(`EID_OFS_STATUS);
    chk(rd, 32'hEF);
    wr(`EID_OFS_STATUS, 32'h20);
    rdr(`EID_OFS_STATUS);
    chk(rd, 32'hCF);
    $display("status done");
  endtask
  task automatic test_done;
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      test_done;
    end
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'h0;
    t_regs;
    t_modes;
    t_status;
    test_done;
  end
endmodule
